// ---- err_pkg.sv ----
// Package of error codes, widths and pair counts for the error capture unit
package err_pkg;
    // Number of flag-code pairs (fixed)
    localparam int PAIRS = 4;
    localparam int PAIR_W = 2;
    // Code width holds the no-error code plus eight causes
    localparam int CODE_W = 4;
    localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;
    localparam logic [CODE_W-1:0] CODE_BAD_ENUM = 4'h1;
    localparam logic [CODE_W-1:0] CODE_BAD_VALUE = 4'h2;
    localparam logic [CODE_W-1:0] CODE_BAD_STATE = 4'h3;
    localparam logic [CODE_W-1:0] CODE_FB_INCOMPLETE = 4'h4;
    localparam logic [CODE_W-1:0] CODE_STACK_OVER = 4'h5;
    localparam logic [CODE_W-1:0] CODE_STACK_UNDER = 4'h6;
    localparam logic [CODE_W-1:0] CODE_MEMORY_EXHAUSTED = 4'h7;
    localparam logic [CODE_W-1:0] CODE_TABLE_TOO_LARGE = 4'h8;
    localparam logic [CODE_W-1:0] CODE_MAX = 4'h8;
    localparam int DATA_W = 32;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;
    // Reporting states, one-hot
    typedef enum logic [1:0] {
        REPORT_IDLE = 2'b01,
        REPORT_DRAIN = 2'b10
    } report_e;
endpackage

// ---- err_classify.sv ----
// Classifier turning command check results into one error code
`timescale 1ns/1ps
module err_classify
    import err_pkg::*;
(
    input wire logic enum_bad,
    input wire logic size_negative,
    input wire logic state_bad,
    input wire logic fb_incomplete,
    input wire logic stack_over,
    input wire logic stack_under,
    input wire logic mem_exhausted,
    input wire logic table_large,
    output logic [CODE_W-1:0] code
);
    // Fixed priority; only the listed checks raise errors
    always_comb begin
        if (enum_bad) begin
            code = CODE_BAD_ENUM;
        end else if (size_negative) begin
            code = CODE_BAD_VALUE;
        end else if (state_bad) begin
            code = CODE_BAD_STATE;
        end else if (fb_incomplete) begin
            code = CODE_FB_INCOMPLETE;
        end else if (stack_over) begin
            code = CODE_STACK_OVER;
        end else if (stack_under) begin
            code = CODE_STACK_UNDER;
        end else if (table_large) begin
            code = CODE_TABLE_TOO_LARGE;
        end else if (mem_exhausted) begin
            code = CODE_MEMORY_EXHAUSTED;
        end else begin
            code = CODE_NONE;
        end
    end
endmodule // err_classify

// ---- err_pairs.sv ----
// Small store of flag-code pairs with registered read data
`timescale 1ns/1ps
module err_pairs
    import err_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [PAIR_W-1:0] wr_idx,
    input wire logic [CODE_W-1:0] wr_code,
    input wire logic clr_en,
    input wire logic [PAIR_W-1:0] clr_idx,
    input wire logic clr_all,
    input wire logic [PAIR_W-1:0] rd_idx,
    output logic [CODE_W-1:0] rd_code,
    output logic [PAIRS-1:0] flags
);
    logic [CODE_W-1:0] codes [PAIRS];

    logic [PAIRS-1:0] drop;
    logic [PAIRS-1:0] take;

    // A pair records when clear, or when cleared in this very cycle
    always_comb begin
        for (int i = 0; i < PAIRS; i++) begin
            drop[i] = clr_all || (clr_en && clr_idx == PAIR_W'(i));
            take[i] = wr_en && wr_idx == PAIR_W'(i) && (!flags[i] || drop[i]);
        end
    end

    // Flags: a new error wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            for (int i = 0; i < PAIRS; i++) begin
                if (take[i]) begin
                    flags[i] <= 1'b1;
                end else if (drop[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    end

    // Codes follow their flags; a set flag keeps its first code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < PAIRS; i++) begin
                codes[i] <= CODE_NONE;
            end
        end else begin
            for (int i = 0; i < PAIRS; i++) begin
                if (take[i]) begin
                    codes[i] <= wr_code;
                end else if (drop[i]) begin
                    codes[i] <= CODE_NONE;
                end
            end
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_code <= CODE_NONE;
        end else begin
            rd_code <= codes[rd_idx];
        end
    end
endmodule // err_pairs

// ---- error_capture.sv ----
// Error capture unit: classify, record, suppress and report error codes
`timescale 1ns/1ps
module error_capture
    import err_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [PAIR_W-1:0] cmd_unit,
    input wire logic cmd_returns,
    input wire logic cmd_writes,
    input wire logic [DATA_W-1:0] cmd_result,
    input wire logic enum_bad,
    input wire logic size_negative,
    input wire logic state_bad,
    input wire logic fb_incomplete,
    input wire logic stack_over,
    input wire logic stack_under,
    input wire logic mem_exhausted,
    input wire logic table_large,
    output logic cmd_commit,
    output logic mem_write_en,
    output logic ret_valid,
    output logic [DATA_W-1:0] ret_data,
    output logic undefined_state,
    input wire logic read_error_query,
    output logic query_done,
    output logic [CODE_W-1:0] query_code
);
    ////////////////////////////////////////////////////////////////////////
    // Classification
    logic [CODE_W-1:0] cls_code;
    logic cmd_err;
    logic [PAIRS-1:0] flags;
    logic [CODE_W-1:0] rd_code;
    logic [PAIR_W-1:0] rd_idx;
    logic clr_en;
    logic clr_all;
    logic [PAIR_W-1:0] clr_idx;
    report_e state;
    logic query_pend;
    logic [PAIR_W-1:0] drain_idx;

    // Fixed set of causes, no-error is zero
    err_classify u_classify (
        .enum_bad(enum_bad),
        .size_negative(size_negative),
        .state_bad(state_bad),
        .fb_incomplete(fb_incomplete),
        .stack_over(stack_over),
        .stack_under(stack_under),
        .mem_exhausted(mem_exhausted),
        .table_large(table_large),
        .code(cls_code)
    );

    assign cmd_err = cmd_valid && (cls_code != CODE_NONE);

    ////////////////////////////////////////////////////////////////////////
    // Pair store
    // Each unit owns one pair; record first error per pair
    err_pairs u_pairs (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(cmd_err),
        .wr_idx(cmd_unit),
        .wr_code(cls_code),
        .clr_en(clr_en),
        .clr_idx(clr_idx),
        .clr_all(clr_all),
        .rd_idx(rd_idx),
        .rd_code(rd_code),
        .flags(flags)
    );

    // Lowest set pair index
    function automatic logic [PAIR_W-1:0] first_set(input logic [PAIRS-1:0] f);
        logic [PAIR_W-1:0] idx;
        idx = '0;
        for (int i = PAIRS - 1; i >= 0; i--) begin
            if (f[i]) begin
                idx = PAIR_W'(i);
            end
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command effects
    // Commit and memory writes gated on error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_commit <= 1'b0;
            mem_write_en <= 1'b0;
        end else begin
            cmd_commit <= cmd_valid && !cmd_err;
            mem_write_en <= cmd_valid && cmd_writes && !cmd_err;
        end
    end

    // Returned value is zero on error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ret_valid <= 1'b0;
            ret_data <= DATA_ZERO;
        end else begin
            ret_valid <= cmd_valid && cmd_returns;
            ret_data <= (cmd_valid && cmd_returns && !cmd_err) ? cmd_result : DATA_ZERO;
        end
    end

    // Sticky undefined marker, memory exhaustion only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            undefined_state <= 1'b0;
        end else if (cmd_err && cls_code == CODE_MEMORY_EXHAUSTED) begin
            undefined_state <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Query sequencing: read pair, then clear it
    assign rd_idx = first_set(flags);
    assign clr_idx = drain_idx;
    assign clr_en = (state == REPORT_DRAIN);
    assign clr_all = read_error_query && state == REPORT_IDLE && flags == '0;

    // Pair under report, frozen when the query is taken; a new error on a
    // lower pair during the drain cannot redirect the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drain_idx <= '0;
        end else if (read_error_query && state == REPORT_IDLE) begin
            drain_idx <= rd_idx;
        end
    end

    // Two-step query: registered code, then answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= REPORT_IDLE;
            query_pend <= 1'b0;
        end else begin
            case (state)
                REPORT_IDLE: begin
                    if (read_error_query && flags != '0) begin
                        state <= REPORT_DRAIN;
                    end
                    query_pend <= read_error_query && flags == '0;
                end
                REPORT_DRAIN: begin
                    state <= REPORT_IDLE;
                    query_pend <= 1'b0;
                end
                default: begin
                    state <= REPORT_IDLE;
                    query_pend <= 1'b0;
                end
            endcase
        end
    end

    // Answer the query one cycle after it is taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            query_done <= 1'b0;
            query_code <= CODE_NONE;
        end else if (state == REPORT_DRAIN) begin
            query_done <= 1'b1;
            query_code <= rd_code;
        end else if (query_pend) begin
            query_done <= 1'b1;
            query_code <= CODE_NONE;
        end else begin
            query_done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    bad_err_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_err |=> !cmd_commit)
        else $error("erroring command committed");
    bad_err_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_err |=> !mem_write_en)
        else $error("erroring command wrote memory");
    zero_return_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_err && cmd_returns) |=> (ret_valid && ret_data == DATA_ZERO))
        else $error("erroring command returned nonzero");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_err && state == REPORT_IDLE && !read_error_query) |=> flags[$past(cmd_unit)])
        else $error("error did not set flag");
    undef_only_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(undefined_state) |-> $past(cls_code) == CODE_MEMORY_EXHAUSTED)
        else $error("undefined state from other code");
    query_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        (read_error_query && state == REPORT_IDLE) |-> ##[1:2] query_done)
        else $error("query not answered");
    none_no_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        (query_done && query_code == CODE_NONE) |-> $past(flags, 2) == '0)
        else $error("no-error returned with flags set");
    drain_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == REPORT_DRAIN && !cmd_err) |=> !flags[$past(clr_idx)])
        else $error("reported pair not cleared");
    code_nonzero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == REPORT_DRAIN) |=> query_code != CODE_NONE)
        else $error("set pair reported as no-error");
    code_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        cls_code <= CODE_MAX)
        else $error("code out of range");

    ////////////////////////////////////////////////////////////////////////
    // Checks on command effects
    commit_clean_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && !cmd_err) |=> cmd_commit)
        else $error("clean command not committed");
    write_clean_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_writes && !cmd_err) |=> mem_write_en)
        else $error("clean write suppressed");
    idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cmd_valid |=> (!cmd_commit && !mem_write_en && !ret_valid))
        else $error("effect without a command");
    ret_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_returns) |=> ret_valid)
        else $error("returned value missing");
    ret_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_returns && !cmd_err) |=> ret_data == $past(cmd_result))
        else $error("clean command returned wrong value");
    undef_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        undefined_state |=> undefined_state)
        else $error("undefined marker dropped");

    ////////////////////////////////////////////////////////////////////////
    // Checks on classification
    enum_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        enum_bad |-> cls_code == CODE_BAD_ENUM)
        else $error("bad enum not classified");
    value_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (size_negative && !enum_bad) |-> cls_code == CODE_BAD_VALUE)
        else $error("negative size not classified");
    mem_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_exhausted && !(enum_bad || size_negative || state_bad || fb_incomplete
            || stack_over || stack_under || table_large)) |-> cls_code == CODE_MEMORY_EXHAUSTED)
        else $error("memory exhaustion not classified");
    clean_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(enum_bad || size_negative || state_bad || fb_incomplete
            || stack_over || stack_under || mem_exhausted || table_large)
        |-> cls_code == CODE_NONE)
        else $error("error raised without a failed check");

    ////////////////////////////////////////////////////////////////////////
    // Checks on reset and the query path
    reset_clear_a: assert property (@(posedge clk)
        !rst_n |=> (flags == '0 && !query_done && query_code == CODE_NONE
            && !undefined_state && !cmd_commit && !mem_write_en && !ret_valid))
        else $error("reset left state behind");
    drain_some_a: assert property (@(posedge clk) disable iff (!rst_n)
        (read_error_query && state == REPORT_IDLE && flags != '0) |=> state == REPORT_DRAIN)
        else $error("set pair not drained");
    drain_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == REPORT_DRAIN |=> state == REPORT_IDLE)
        else $error("drain lasted more than one cycle");
    pend_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        (read_error_query && state == REPORT_IDLE && flags == '0)
        |=> ##1 (query_done && query_code == CODE_NONE))
        else $error("empty query not answered with no-error");
    answer_asked_a: assert property (@(posedge clk) disable iff (!rst_n)
        query_done |-> $past(read_error_query, 2))
        else $error("answer without a query");
    code_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(query_code) |-> query_done)
        else $error("answer code changed without an answer");
    last_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == REPORT_DRAIN && $onehot(flags) && !cmd_err) |=> flags == '0)
        else $error("flags left after last report");

    // Coverage of main scenarios
    cv_err_c: cover property (@(posedge clk) disable iff (!rst_n) cmd_err);
    cv_query_c: cover property (@(posedge clk) disable iff (!rst_n)
        query_done && query_code != CODE_NONE);
    cv_two_c: cover property (@(posedge clk) disable iff (!rst_n)
        state == REPORT_DRAIN ##2 state == REPORT_DRAIN);
    cv_mem_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(undefined_state));
    cv_none_c: cover property (@(posedge clk) disable iff (!rst_n)
        query_done && query_code == CODE_NONE);
endmodule // error_capture

// ---- host_model.sv ----
// Host command source model: issues commands and error queries
`timescale 1ns/1ps
module host_model
    import err_pkg::*;
(
    input wire logic clk,
    input wire logic query_done,
    output logic cmd_valid,
    output logic [PAIR_W-1:0] cmd_unit,
    output logic cmd_returns,
    output logic cmd_writes,
    output logic [DATA_W-1:0] cmd_result,
    output logic [7:0] checks,
    output logic read_error_query
);
    // Idle levels at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_unit = 2'h0;
        cmd_returns = 1'b0;
        cmd_writes = 1'b0;
        cmd_result = 32'h0;
        checks = 8'h00;
        read_error_query = 1'b0;
    end

    // One command, held for one edge; check bits in cause order from bit 0
    task automatic send(input logic [PAIR_W-1:0] unit, input logic [7:0] chk,
                        input logic rets, input logic wrs, input logic [DATA_W-1:0] res);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_unit = unit;
        checks = chk;
        cmd_returns = rets;
        cmd_writes = wrs;
        cmd_result = res;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        checks = 8'h00;
        cmd_result = ~res; // Stale value never looks valid
    endtask

    // One query pulse, then a bounded wait for the answer
    task automatic ask(output int waited);
        waited = 0;
        @(posedge clk);
        #1;
        read_error_query = 1'b1;
        @(posedge clk);
        #1;
        read_error_query = 1'b0;
        while (query_done !== 1'b1 && waited < 4) begin
            @(posedge clk);
            #1;
            waited++;
        end
    endtask
endmodule // host_model

// ---- testbench.sv ----
// Self-checking testbench for the error capture unit
`timescale 1ns/1ps
module testbench;
    import err_pkg::*;
    logic clk;
    logic rst_n;
    logic cmd_valid, cmd_returns, cmd_writes, read_error_query;
    logic [PAIR_W-1:0] cmd_unit;
    logic [DATA_W-1:0] cmd_result, ret_data;
    logic [7:0] checks;
    logic cmd_commit, mem_write_en, ret_valid, undefined_state, query_done;
    logic [CODE_W-1:0] query_code;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, partner and design
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    host_model u_host (.clk(clk), .query_done(query_done), .cmd_valid(cmd_valid),
        .cmd_unit(cmd_unit), .cmd_returns(cmd_returns), .cmd_writes(cmd_writes),
        .cmd_result(cmd_result), .checks(checks), .read_error_query(read_error_query));

    error_capture u_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_unit(cmd_unit), .cmd_returns(cmd_returns), .cmd_writes(cmd_writes),
        .cmd_result(cmd_result), .enum_bad(checks[0]), .size_negative(checks[1]),
        .state_bad(checks[2]), .fb_incomplete(checks[3]), .stack_over(checks[4]),
        .stack_under(checks[5]), .mem_exhausted(checks[6]), .table_large(checks[7]),
        .cmd_commit(cmd_commit), .mem_write_en(mem_write_en), .ret_valid(ret_valid),
        .ret_data(ret_data), .undefined_state(undefined_state),
        .read_error_query(read_error_query), .query_done(query_done),
        .query_code(query_code));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask

    // Query, then compare code and answer latency
    task automatic q(input logic [CODE_W-1:0] exp, input int ew);
        int w;
        u_host.ask(w);
        chk(query_done, 1'b1, "query done");
        chk(query_code, exp, "query code");
        chk(w, ew, "query latency");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk({cmd_commit, mem_write_en, ret_valid, query_done, undefined_state}, 0, "idle");
        chk(query_code, CODE_NONE, "reset code");
        q(CODE_NONE, 1);
    endtask

    task automatic t_clean();
        u_host.send(2'h2, 8'h00, 1'b1, 1'b1, 32'hcafe_0001);
        chk({cmd_commit, mem_write_en, ret_valid}, 3'b111, "clean ok");
        chk(ret_data, 32'hcafe_0001, "clean data");
        u_host.send(2'h2, 8'h00, 1'b0, 1'b0, 32'h5a5a_0002);
        chk({cmd_commit, mem_write_en, ret_valid}, 3'b100, "plain");
        q(CODE_NONE, 1);
    endtask

    task automatic t_sticky();
        u_host.send(2'h1, 8'h02, 1'b0, 1'b0, 32'h0);
        u_host.send(2'h1, 8'h10, 1'b0, 1'b0, 32'h0);
        chk(cmd_commit, 1'b0, "second error");
        q(CODE_BAD_VALUE, 1);
        q(CODE_NONE, 1);
    endtask

    task automatic t_multi();
        u_host.send(2'h3, 8'h04, 1'b0, 1'b0, 32'h0);
        u_host.send(2'h1, 8'h80, 1'b0, 1'b0, 32'h0);
        u_host.send(2'h2, 8'h08, 1'b0, 1'b0, 32'h0);
        q(CODE_TABLE_TOO_LARGE, 1);
        q(CODE_FB_INCOMPLETE, 1);
        q(CODE_BAD_STATE, 1);
        q(CODE_NONE, 1);
    endtask

    // Every cause alone; memory exhaustion comes seventh
    task automatic t_codes();
        for (int i = 0; i < 8; i++) begin
            u_host.send(2'h0, 8'h01 << i, 1'b1, 1'b1, 32'h1234_5678);
            chk({cmd_commit, mem_write_en, ret_valid}, 3'b001, "refused");
            chk(ret_data, DATA_ZERO, "zero return");
            chk(undefined_state, i >= 6, "undefined");
            q(CODE_W'(i + 1), 1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and timeout
    initial begin
        rst_n = 1'b0;
        do_reset();
        t_reset();
        t_clean();
        t_sticky();
        t_multi();
        t_codes();
        do_reset();
        chk(undefined_state, 1'b0, "cleared");
        summarize();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
endmodule // testbench
